// *** pll_clock_synth_control.v ***
// Behavioural clock synthesiser tile with APB control registers.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pll_synth_consts.vh"
// Notes on behaviour
// - Output equals ref times m over n times c
// - Phase offset in eighth oscillator period steps
// - Each output divider has its own duty
// - Three synthesised clocks for global distribution
// - Third divider also drives external pin
// - Runtime choice between two reference clocks
// - Lock held low for programmed transitions
// - Gated or ungated lock selectable for output
// - Zero delay mode aligns external pin
// - Normal mode cancels global network delay
// - No compensation mode applies no offset
// - Run enable starts and stops synthesiser
// - Asynchronous restart resynchronises synthesiser
// - Detector gate passes or blocks detector
// - Differential reference uses both pins
// - Select control drives reference multiplexer
module pll_clock_synth_control #(
  parameter [19:0] NORM_COMP = 20'h00000,
  parameter [19:0] ZDB_COMP = 20'h00000
) (
  input wire clk_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output reg pslverr_o,
  input wire ref_a_i,
  input wire ref_b_i,
  input wire ref_select_i,
  input wire run_enable_i,
  input wire restart_i,
  input wire detector_gate_i,
  output wire [2:0] out_clk_o,
  output wire ext_clk_o,
  output wire lock_o,
  output wire lock_ungated_o
);
  reg [5:0] m_r;
  reg [2:0] n_r;
  reg [5:0] c_r [0:2];
  reg [8:0] duty_r [0:2];
  reg [8:0] phase_r [0:2];
  reg [1:0] fb_r;
  reg lock_sel_r, refsel_r, dyn_r, diff_r, ext_en_r;
  reg [15:0] hold_cfg_r;
  reg [2:0] sync1_r, sync2_r;
  reg ref_prev_r, sel_prev_r, stable_r, hold_done_r;
  reg [15:0] per_cnt_r, per_r, hold_cnt_r;
  reg [19:0] acc_r;
  reg eighth_r;
  reg [2:0] clk_r;
  reg [8:0] pos_r [0:2];
  wire ref_now, sel_now, active, ref_rise, ref_edge, switch_evt;
  wire [5:0] m_eff;
  wire [2:0] n_eff;
  wire [19:0] step, thresh, acc_sum, comp, pre_sum;
  wire [15:0] per_new, per_diff;
  wire lock_raw, lock_gated;
  wire setup, wr;
  integer i;

  // Pin references pass two flops; restart is asynchronous so it is synchronised too.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end
    else
    begin
      sync1_r <= {restart_i, ref_b_i, ref_a_i};
      sync2_r <= sync1_r;
    end
  end

  assign sel_now = diff_r ? 1'b0 : (dyn_r ? ref_select_i : refsel_r);
  assign ref_now = diff_r ? (sync2_r[0] & ~sync2_r[1]) : (sel_now ? sync2_r[1] : sync2_r[0]);
  assign active = run_enable_i & ~sync2_r[2];
  assign ref_rise = ref_now & ~ref_prev_r;
  assign ref_edge = ref_now ^ ref_prev_r;
  assign switch_evt = sel_now ^ sel_prev_r;
  // Zero values would stall the divider, so they are treated as one.
  assign m_eff = (m_r == 6'h00) ? 6'h01 : m_r;
  assign n_eff = (n_r == 3'h0) ? 3'h1 : n_r;
  // eighth-tick rate eight times m over n times reference
  assign step = {11'h000, m_eff, 3'b000};
  assign thresh = {4'h0, per_r} * {17'h00000, n_eff};
  assign acc_sum = acc_r + step;
  // The realign edge still advances one step, so no eighth tick is lost per reference period.
  assign pre_sum = comp + step;
  assign per_new = per_cnt_r + 16'h0001;
  assign per_diff = (per_new > per_r) ? (per_new - per_r) : (per_r - per_new);
  assign comp = (fb_r == `FB_ZDB) ? ZDB_COMP : NORM_COMP;

  // Reference period measurement, detector realignment and lock hold-off.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_prev_r <= 1'b0;
      sel_prev_r <= 1'b0;
      per_cnt_r <= 16'h0000;
      per_r <= 16'h0000;
      stable_r <= 1'b0;
      hold_cnt_r <= 16'h0000;
      hold_done_r <= 1'b0;
      acc_r <= 20'h00000;
      eighth_r <= 1'b0;
    end
    else
    begin
      ref_prev_r <= ref_now;
      sel_prev_r <= sel_now;
      if (!active || switch_evt)
      begin
        per_cnt_r <= 16'h0000;
        per_r <= 16'h0000;
        stable_r <= 1'b0;
        hold_cnt_r <= 16'h0000;
        hold_done_r <= 1'b0;
        acc_r <= 20'h00000;
        eighth_r <= 1'b0;
      end
      else
      begin
        per_cnt_r <= ref_rise ? 16'h0000 : per_cnt_r + 16'h0001;
        if (ref_rise && detector_gate_i)
        begin
          per_r <= per_new;
          stable_r <= (per_r != 16'h0000) && (per_diff <= 16'h0001);
        end
        if (ref_edge && stable_r && !hold_done_r)
        begin
          hold_cnt_r <= hold_cnt_r + 16'h0001;
          hold_done_r <= (hold_cnt_r + 16'h0001) >= hold_cfg_r;
        end
        // Only one eighth tick per cycle: the eighth rate must stay below the system clock.
        if (ref_rise && detector_gate_i && fb_r != `FB_NOCOMP)
        begin
          if (pre_sum >= thresh)
          begin
            acc_r <= pre_sum - thresh;
            eighth_r <= 1'b1;
          end
          else
          begin
            acc_r <= pre_sum;
            eighth_r <= 1'b0;
          end
        end
        else if (per_r != 16'h0000 && acc_sum >= thresh)
        begin
          acc_r <= acc_sum - thresh;
          eighth_r <= 1'b1;
        end
        else
        begin
          acc_r <= (per_r != 16'h0000) ? acc_sum : 20'h00000;
          eighth_r <= 1'b0;
        end
      end
    end
  end

  // Each output divider counts eighth ticks over a period of eight times its post-scale value.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gen_div
      wire [5:0] c_eff;
      wire [8:0] per_e, ph, shifted;
      assign c_eff = (c_r[g] == 6'h00) ? 6'h01 : c_r[g];
      assign per_e = {c_eff, 3'b000};
      assign ph = (phase_r[g] < per_e) ? phase_r[g] : 9'h000;
      assign shifted = (pos_r[g] >= ph) ? (pos_r[g] - ph) : (pos_r[g] + per_e - ph);
      always @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          pos_r[g] <= 9'h000;
          clk_r[g] <= 1'b0;
        end
        else if (!active || !stable_r)
        begin
          pos_r[g] <= 9'h000;
          clk_r[g] <= 1'b0;
        end
        else
        begin
          clk_r[g] <= shifted < duty_r[g];
          if (eighth_r)
            pos_r[g] <= (pos_r[g] + 9'h001 >= per_e) ? 9'h000 : pos_r[g] + 9'h001;
        end
      end
    end
  endgenerate

  assign out_clk_o = clk_r;
  assign ext_clk_o = clk_r[2] & ext_en_r;
  assign lock_raw = stable_r & active;
  assign lock_gated = lock_raw & hold_done_r;
  assign lock_o = lock_sel_r ? lock_gated : lock_raw;
  assign lock_ungated_o = lock_raw;

  // APB slave: zero wait states, read data captured in the setup cycle.
  assign pready_o = 1'b1;
  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pwrite_i;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      m_r <= `RST_M;
      n_r <= `RST_N;
      for (i = 0; i < 3; i = i + 1)
      begin
        c_r[i] <= `RST_C;
        duty_r[i] <= `RST_DUTY;
        phase_r[i] <= `RST_PHASE;
      end
      fb_r <= `RST_FB;
      lock_sel_r <= 1'b1;
      refsel_r <= 1'b0;
      dyn_r <= 1'b0;
      diff_r <= 1'b0;
      ext_en_r <= 1'b1;
      hold_cfg_r <= `RST_HOLD;
    end
    else if (wr)
    begin
      if (paddr_i == `OFS_MULT)
      begin
        m_r <= pwdata_i[`MULT_M_LSB +: 6];
        n_r <= pwdata_i[`MULT_N_LSB +: 3];
      end
      else if (paddr_i == `OFS_DIV0 || paddr_i == `OFS_DIV1 || paddr_i == `OFS_DIV2)
      begin
        c_r[paddr_i[3:2] - 2'h1] <= pwdata_i[`DIV_C_LSB +: 6];
        duty_r[paddr_i[3:2] - 2'h1] <= pwdata_i[`DIV_DUTY_LSB +: 9];
        phase_r[paddr_i[3:2] - 2'h1] <= pwdata_i[`DIV_PHASE_LSB +: 9];
      end
      else if (paddr_i == `OFS_CFG)
      begin
        fb_r <= pwdata_i[`CFG_FB_LSB +: 2];
        lock_sel_r <= pwdata_i[`CFG_LOCKSEL_BIT];
        refsel_r <= pwdata_i[`CFG_REFSEL_BIT];
        dyn_r <= pwdata_i[`CFG_DYN_BIT];
        diff_r <= pwdata_i[`CFG_DIFF_BIT];
        ext_en_r <= pwdata_i[`CFG_EXTEN_BIT];
        hold_cfg_r <= pwdata_i[`CFG_HOLD_LSB +: 16];
      end
    end
  end

  // Read mux and error flag are registered so both are steady through the access cycle.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_o <= 1'b0;
      if (paddr_i == `OFS_MULT)
        prdata_o <= {21'h000000, n_r, 2'b00, m_r};
      else if (paddr_i == `OFS_DIV0 || paddr_i == `OFS_DIV1 || paddr_i == `OFS_DIV2)
        prdata_o <= {3'h0, phase_r[paddr_i[3:2] - 2'h1], 3'h0, duty_r[paddr_i[3:2] - 2'h1], 2'b00,
          c_r[paddr_i[3:2] - 2'h1]};
      else if (paddr_i == `OFS_CFG)
        prdata_o <= {hold_cfg_r, 9'h000, ext_en_r, diff_r, dyn_r, refsel_r, lock_sel_r, fb_r};
      else if (paddr_i == `OFS_STATUS)
        prdata_o <= {per_r, 12'h000, active, sel_now, lock_gated, lock_raw};
      else
      begin
        prdata_o <= 32'h00000000;
        pslverr_o <= 1'b1;
      end
    end
  end
endmodule // pll_clock_synth_control
`default_nettype wire

// *** pll_synth_consts.vh ***
// Register offsets, field positions and reset values of the clock synthesiser control block.
`ifndef PLL_SYNTH_CONSTS_VH
`define PLL_SYNTH_CONSTS_VH
`define OFS_MULT 12'h000
`define OFS_DIV0 12'h004
`define OFS_DIV1 12'h008
`define OFS_DIV2 12'h00C
`define OFS_CFG 12'h010
`define OFS_STATUS 12'h014
`define MULT_M_LSB 0
`define MULT_N_LSB 8
`define DIV_C_LSB 0
`define DIV_DUTY_LSB 8
`define DIV_PHASE_LSB 20
`define CFG_FB_LSB 0
`define CFG_LOCKSEL_BIT 2
`define CFG_REFSEL_BIT 3
`define CFG_DYN_BIT 4
`define CFG_DIFF_BIT 5
`define CFG_EXTEN_BIT 6
`define CFG_HOLD_LSB 16
`define RST_M 6'h01
`define RST_N 3'h1
`define RST_C 6'h01
`define RST_DUTY 9'h004
`define RST_PHASE 9'h000
`define RST_FB 2'h1
`define RST_HOLD 16'h0010
`define FB_NOCOMP 2'h0
`define FB_NORMAL 2'h1
`define FB_ZDB 2'h2
`define EIGHTHS 4'h8
`endif

// *** synth_checker_properties.sv ***
// Port checker for the clock synthesiser control block.
`timescale 1ns/1ps
`default_nettype none
module synth_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic run_enable_i,
  input wire logic restart_i,
  input wire logic detector_gate_i,
  input wire logic [2:0] out_clk_o,
  input wire logic ext_clk_o,
  input wire logic lock_o,
  input wire logic lock_ungated_o
);
  // One clock domain, so every check shares one clock and one reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_EXT: assert property (ext_clk_o |-> out_clk_o[2])
    else $error("external clock high while third output low");
  AST_RUN_CLK: assert property (!run_enable_i [*3] |-> out_clk_o == 3'h0)
    else $error("outputs toggle while disabled");
  AST_RUN_LOCK: assert property (!run_enable_i [*3] |-> !lock_o && !lock_ungated_o)
    else $error("lock reported while disabled");
  AST_RST_CLK: assert property (restart_i [*4] |-> out_clk_o == 3'h0)
    else $error("outputs toggle during restart");
  AST_RST_LOCK: assert property (restart_i [*4] |-> !lock_o && !lock_ungated_o)
    else $error("lock reported during restart");
  AST_LOCK_SUB: assert property (lock_o |-> lock_ungated_o)
    else $error("lock output high without stable outputs");
  AST_GATE: assert property ($rose(lock_ungated_o) |-> $past(detector_gate_i) || $past(detector_gate_i, 2))
    else $error("lock gained with detector blocked");
  AST_RUN_UNG: assert property (lock_ungated_o |-> $past(run_enable_i))
    else $error("ungated lock without run enable");
endmodule // synth_checker
bind pll_clock_synth_control synth_checker chk (.clk_i(clk_i), .rstn_i(rstn_i), .run_enable_i(run_enable_i),
  .restart_i(restart_i), .detector_gate_i(detector_gate_i), .out_clk_o(out_clk_o), .ext_clk_o(ext_clk_o),
  .lock_o(lock_o), .lock_ungated_o(lock_ungated_o));
`default_nettype wire

// *** ref_source.sv ***
// Reference clock pins that feed the synthesiser.
`timescale 1ns/1ps
`default_nettype none
module ref_source #(
  parameter int HALF_A = 250,
  parameter int HALF_B = 350
) (
  input wire logic diff_i,
  output logic ref_a_o,
  output logic ref_b_o
);
  logic a_r = 1'b0;
  logic b_r = 1'b0;
  initial forever #(HALF_A) a_r = ~a_r;
  initial forever #(HALF_B) b_r = ~b_r;
  assign ref_a_o = a_r;
  assign ref_b_o = diff_i ? ~a_r : b_r;
endmodule // ref_source
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the clock synthesiser control block.
`timescale 1ns/1ps
`default_nettype none
`include "pll_synth_consts.vh"
module testbench;
  logic clk, rstn, psel, pen, pwr, rsel, run, rst, gate, diff, pready, pslverr, e, ra, rb, ec, lk, lku;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] oc;
  int err_count, compares, cyc, pc;
  ref_source src (.diff_i(diff), .ref_a_o(ra), .ref_b_o(rb));
  pll_clock_synth_control DUT (.clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ref_a_i(ra), .ref_b_i(rb), .ref_select_i(rsel), .run_enable_i(run), .restart_i(rst),
    .detector_gate_i(gate), .out_clk_o(oc), .ext_clk_o(ec), .lock_o(lk), .lock_ungated_o(lku));
  // System clock at 40 MHz.
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // A hung wait would otherwise never reach the verdict.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      wrap_up();
    end
  end
  task wrap_up();
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      $display("[ERR] %s expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task rd(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(0, a, 0);
    chk(n, x, q & m);
  endtask
  task cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wait_lock(input logic want);
    int n;
    n = 0;
    while (lk !== want && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    chk("lock", want, lk);
  endtask
  // Counts one period and its high time, in system clocks, from a rising edge.
  task meas(input int i, input int per, input int hi);
    int p, h, x;
    logic v;
    p = 0;
    h = 0;
    x = 0;
    @(posedge oc[i]);
    #1;
    do
    begin
      h += oc[i];
      x += ec;
      p++;
      v = oc[i];
      @(posedge clk);
      #1;
    end
    while (!(oc[i] && !v));
    chk("period", per, p);
    chk("high", hi, h);
    if (i == 2)
      chk("ext_high", hi, x);
  endtask
  // Main sequence.
  initial
  begin
    {psel, pen, pwr, rsel, run, rst, gate, diff, rstn} = 0;
    paddr = 0;
    pwdata = 0;
    cycles(10);
    rstn <= 1;
    rd("mult", `OFS_MULT, 32'hFFFFFFFF, 32'h00000101);
    rd("div2", `OFS_DIV2, 32'hFFFFFFFF, 32'h00000401);
    rd("cfg", `OFS_CFG, 32'hFFFFFFFF, 32'h00100045);
    rd("unmapped", 12'h018, 32'hFFFFFFFF, 32'h00000000);
    chk("slverr", 1, e);
    apb(1, `OFS_STATUS, 32'h0000000F);
    rd("status", `OFS_STATUS, 32'hF, 32'h0);
    apb(1, `OFS_MULT, 32'h00000102);
    apb(1, `OFS_DIV1, 32'h00000402);
    apb(1, `OFS_DIV2, 32'h00001004);
    apb(1, `OFS_CFG, 32'h00040045);
    run <= 1;
    gate <= 1;
    wait_lock(1);
    rd("status", `OFS_STATUS, 32'hF, 32'hB);
    meas(0, 10, 5);
    meas(1, 20, 5);
    meas(2, 40, 20);
    @(posedge clk);
    run <= 0;
    cycles(4);
    chk("lock", 0, lk);
    chk("clocks", 0, oc);
    gate <= 0;
    run <= 1;
    cycles(400);
    chk("ungated", 0, lku);
    gate <= 1;
    wait_lock(1);
    rst <= 1;
    cycles(4);
    chk("lock", 0, lk);
    chk("clocks", 0, oc);
    rst <= 0;
    wait_lock(1);
    apb(1, `OFS_CFG, 32'h00040055);
    rsel <= 1;
    wait_lock(0);
    wait_lock(1);
    rd("status", `OFS_STATUS, 32'hF, 32'hF);
    apb(1, `OFS_CFG, 32'h00040071);
    diff <= 1;
    wait_lock(0);
    wait_lock(1);
    rd("status", `OFS_STATUS, 32'h7, 32'h1);
    apb(1, `OFS_CFG, 32'h00040072);
    meas(0, 10, 5);
    apb(1, `OFS_CFG, 32'h00040070);
    meas(0, 10, 5);
    // Half a period of phase on the first divider puts its rise five clocks after the second one.
    apb(1, `OFS_DIV0, 32'h00400401);
    @(posedge oc[1]);
    #1;
    pc = 0;
    do
    begin
      @(posedge clk);
      #1;
      pc++;
    end
    while (!oc[0] && pc < 100);
    chk("phase", 5, pc);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
